/* File: hdl/eoc_defines.vh */
// constants for the external oscillator control block
//
// Overview of operation
// - control register at address 0x9f, page 0x0f, all bits reset to zero
// - bit 7 read-only crystal valid flag, 1 once crystal runs stable
// - mode field 00x switches the oscillator circuit off
// - mode 010 cmos clock input, 011 cmos clock halved
// - mode 100 rc oscillator, 101 capacitor oscillator
// - mode 110 crystal oscillator, 111 crystal oscillator halved
// - bit 3 unused, reads zero, software writes zero
// - bits 2:0 read-write drive range for crystal and rc modes
// - capacitor mode codes 000..111 pick eight rising k factors 0.87..1590
// - crystal mode uses both pins, other enabled modes only output pin, 00x neither pin
`ifndef EOC_DEFINES_VH
`define EOC_DEFINES_VH

`define EOC_CTRL_ADDR      8'h9f
`define EOC_CTRL_PAGE      8'h0f
`define EOC_CTRL_RESET     8'h00
`define EOC_VALID_BIT      7
`define EOC_MODE_HI        6
`define EOC_MODE_LO        4
`define EOC_UNUSED_BIT     3
`define EOC_DRIVE_HI       2
`define EOC_DRIVE_LO       0
`define EOC_MODE_CMOS      3'h2
`define EOC_MODE_CMOS_DIV  3'h3
`define EOC_MODE_RC        3'h4
`define EOC_MODE_CAP       3'h5
`define EOC_MODE_XTAL      3'h6
`define EOC_MODE_XTAL_DIV  3'h7
`define EOC_KF_0           18'd87
`define EOC_KF_1           18'd260
`define EOC_KF_2           18'd770
`define EOC_KF_3           18'd2200
`define EOC_KF_4           18'd6500
`define EOC_KF_5           18'd18000
`define EOC_KF_6           18'd66400
`define EOC_KF_7           18'd159000

`endif

/* File: hdl/eoc_clock_halver.v */
// divide-by-two stage for the selected oscillator clock
`timescale 1ns/10ps
`default_nettype none

module eoc_clock_halver (
  input  wire clk,
  input  wire rst_n,
  input  wire enable,
  input  wire halve,
  input  wire src_level,
  output reg  clk_out
);

  reg prev_level;
  reg half_level;

  // track source edges and toggle on rising ones
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_level <= 1'b0;
      half_level <= 1'b0;
      clk_out    <= 1'b0;
    end else if (!enable) begin
      prev_level <= src_level; // no false edge when enabled on a high pin
      half_level <= 1'b0;
      clk_out    <= 1'b0;
    end else begin
      prev_level <= src_level;
      if (src_level && !prev_level) begin
        half_level <= ~half_level;
      end
      clk_out <= halve ? half_level : src_level;
    end
  end

endmodule // eoc_clock_halver

`default_nettype wire

/* File: hdl/eoc_ext_osc_ctrl.v */
// external oscillator control register and clock selection
`timescale 1ns/10ps
`default_nettype none
`include "eoc_defines.vh"

module eoc_ext_osc_ctrl (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_page,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  output wire        sfr_hit,
  input  wire        crystal_stable,
  input  wire        oscillator_input_pin,
  input  wire        oscillator_output_pin,
  output wire        osc_enable,
  output wire        input_pin_claimed,
  output wire        output_pin_claimed,
  output wire        crystal_mode,
  output wire        rc_mode,
  output wire        cap_mode,
  output wire        cmos_mode,
  output wire [2:0]  drive_frequency_control,
  output reg  [17:0] k_factor_x100,
  output wire        ext_clk_out
);

  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  // positions of the asynchronous inputs in the synchroniser bank
  localparam IN_PIN  = 0;
  localparam OUT_PIN = 1;
  localparam STABLE  = 2;
  localparam N_ASYNC = 3;

  reg                rst_meta;
  reg                rst_sync_n;
  wire [N_ASYNC-1:0] async_in;
  wire [N_ASYNC-1:0] async_sync;
  wire               in_pin_sync;
  wire               out_pin_sync;
  wire               stable_sync;
  genvar             gi;

  // reset release through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // asynchronous inputs gathered into the bank
  assign async_in[IN_PIN]  = oscillator_input_pin;
  assign async_in[OUT_PIN] = oscillator_output_pin;
  assign async_in[STABLE]  = crystal_stable;

  // two flops per pin and detector input
  generate
    for (gi = 0; gi < N_ASYNC; gi = gi + 1) begin : g_sync
      reg sync_meta;
      reg sync_out;
      always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          sync_meta <= 1'b0;
          sync_out  <= 1'b0;
        end else begin
          sync_meta <= async_in[gi];
          sync_out  <= sync_meta;
        end
      end
      assign async_sync[gi] = sync_out;
    end
  endgenerate

  // only the second flop of each pair is read
  assign in_pin_sync  = async_sync[IN_PIN];
  assign out_pin_sync = async_sync[OUT_PIN];
  assign stable_sync  = async_sync[STABLE];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  reg  [2:0] oscillator_mode_select;
  reg  [2:0] drive_field;
  reg        crystal_valid_flag;
  reg        next_valid_flag;
  reg  [7:0] next_rdata;
  wire       ctrl_sel;
  wire       ctrl_wr;
  wire       ctrl_rd;

  assign ctrl_sel = (sfr_addr == `EOC_CTRL_ADDR) && (sfr_page == `EOC_CTRL_PAGE);
  assign ctrl_wr  = ctrl_sel && sfr_wr;
  assign ctrl_rd  = ctrl_sel && sfr_rd;
  assign sfr_hit  = ctrl_wr || ctrl_rd;

  // mode field, reset zero leaves circuit off
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      oscillator_mode_select <= 3'h0;
    end else if (ctrl_wr) begin
      oscillator_mode_select <= sfr_wdata[`EOC_MODE_HI:`EOC_MODE_LO];
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      drive_field <= 3'h0;
    end else if (ctrl_wr) begin
      drive_field <= sfr_wdata[`EOC_DRIVE_HI:`EOC_DRIVE_LO];
    end
  end

  // valid only while crystal mode stable
  always @* begin
    next_valid_flag = crystal_mode && stable_sync;
  end

  // valid flag register, cleared outright outside crystal modes
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      crystal_valid_flag <= 1'b0;
    end else begin
      crystal_valid_flag <= next_valid_flag;
    end
  end

  // read data assembled, bit 3 zero
  always @* begin
    next_rdata = 8'h00;
    if (ctrl_rd) begin
      next_rdata[`EOC_VALID_BIT]              = crystal_valid_flag;
      next_rdata[`EOC_MODE_HI:`EOC_MODE_LO]   = oscillator_mode_select;
      next_rdata[`EOC_UNUSED_BIT]             = 1'b0;
      next_rdata[`EOC_DRIVE_HI:`EOC_DRIVE_LO] = drive_field;
    end
  end

  // read data register, zero outside read cycles
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // circuit off for 00x
  assign osc_enable   = oscillator_mode_select[2] | oscillator_mode_select[1];
  assign cmos_mode    = (oscillator_mode_select[2:1] == 2'h1);
  assign rc_mode      = (oscillator_mode_select == `EOC_MODE_RC);
  assign cap_mode     = (oscillator_mode_select == `EOC_MODE_CAP);
  assign crystal_mode = (oscillator_mode_select[2:1] == 2'h3);
  assign input_pin_claimed  = crystal_mode;
  assign output_pin_claimed = osc_enable;
  // range applied in crystal and rc
  assign drive_frequency_control = (crystal_mode || rc_mode) ? drive_field : 3'h0;

  reg [17:0] next_k_factor;

  always @* begin
    case (drive_field)
      3'h0:    next_k_factor = `EOC_KF_0;
      3'h1:    next_k_factor = `EOC_KF_1;
      3'h2:    next_k_factor = `EOC_KF_2;
      3'h3:    next_k_factor = `EOC_KF_3;
      3'h4:    next_k_factor = `EOC_KF_4;
      3'h5:    next_k_factor = `EOC_KF_5;
      3'h6:    next_k_factor = `EOC_KF_6;
      default: next_k_factor = `EOC_KF_7;
    endcase
    if (!cap_mode) begin
      next_k_factor = 18'd0; // meaningless outside capacitor mode
    end
  end

  // k factor register, needs 18 bits for the top code
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      k_factor_x100 <= 18'd0;
    end else begin
      k_factor_x100 <= next_k_factor;
    end
  end

  // ----------------------------------------------------------------
  // clock presentation
  // ----------------------------------------------------------------
  wire src_level;
  wire halve;

  // crystal senses input pin, others output pin
  assign src_level = crystal_mode ? in_pin_sync : out_pin_sync;
  assign halve     = oscillator_mode_select[0] && oscillator_mode_select[1];

  eoc_clock_halver u_halver (
    .clk       (clk),
    .rst_n     (rst_sync_n),
    .enable    (osc_enable),
    .halve     (halve),
    .src_level (src_level),
    .clk_out   (ext_clk_out)
  );

endmodule // eoc_ext_osc_ctrl

`default_nettype wire

/* File: testbench/eoc_chk.sv */
// assertions on the oscillator control ports
`timescale 1ns/10ps
`default_nettype none
module eoc_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        sfr_rd,
  input wire logic        sfr_wr,
  input wire logic        sfr_hit,
  input wire logic        osc_enable,
  input wire logic        ext_clk_out,
  input wire logic        input_pin_claimed,
  input wire logic        output_pin_claimed,
  input wire logic        crystal_mode,
  input wire logic        rc_mode,
  input wire logic        cap_mode,
  input wire logic        cmos_mode,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic [2:0]  drive_frequency_control,
  input wire logic [17:0] k_factor_x100
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // register read and write taken
  sequence s_rd; sfr_hit && sfr_rd; endsequence
  sequence s_wr; sfr_hit && sfr_wr; endsequence
  sequence s_wr_cap_top; s_wr ##0 (sfr_wdata[6:4] == 3'h5 && sfr_wdata[2:0] == 3'h7); endsequence
  a_rd_bit3: assert property (s_rd |=> !sfr_rdata[3]) else $error("unused bit set");
  a_wr_off: assert property (s_wr and sfr_wdata[6:5] == 2'b00 |=> !osc_enable) else $error("not off");
  a_wr_rc: assert property (s_wr |=> rc_mode == ($past(sfr_wdata[6:4]) == 3'h4)) else $error("rc decode");
  a_wr_xtal: assert property (s_wr |=> crystal_mode == ($past(sfr_wdata[6:5]) == 2'b11)) else $error("xtal");
  a_wr_drive: assert property (s_wr and sfr_wdata[6:5] == 2'b11 |=>
    drive_frequency_control == $past(sfr_wdata[2:0])) else $error("drive not kept");
  a_drive_gate: assert property (!crystal_mode && !rc_mode |-> drive_frequency_control == 3'h0)
    else $error("drive leaks");
  a_pin_xtal: assert property (input_pin_claimed == crystal_mode) else $error("input pin claim");
  a_off_idle: assert property ((!osc_enable)[*3] |-> !ext_clk_out) else $error("clock while off");
  a_valid_off: assert property (s_rd and !crystal_mode && $past(!crystal_mode) |=> !sfr_rdata[7])
    else $error("valid outside crystal");
  a_wr_cmos: assert property (s_wr |=> cmos_mode == ($past(sfr_wdata[6:5]) == 2'b01)) else $error("cmos");
  a_wr_claim: assert property (s_wr |=> output_pin_claimed == ($past(sfr_wdata[6:5]) != 2'b00))
    else $error("output pin claim");
  a_kf_top: assert property (s_wr_cap_top |=> ##1 k_factor_x100 == 18'd159000) else $error("k factor top");
  a_kf_off: assert property (!cap_mode |=> k_factor_x100 == 18'd0) else $error("k factor outside cap");
  a_rd_idle: assert property (!s_rd |=> sfr_rdata == 8'h00) else $error("read data lingers");
endmodule // eoc_chk
bind eoc_ext_osc_ctrl eoc_chk chk (
  .clk                     (clk),
  .rst_n                   (rst_n),
  .sfr_rd                  (sfr_rd),
  .sfr_wr                  (sfr_wr),
  .sfr_hit                 (sfr_hit),
  .osc_enable              (osc_enable),
  .ext_clk_out             (ext_clk_out),
  .input_pin_claimed       (input_pin_claimed),
  .output_pin_claimed      (output_pin_claimed),
  .crystal_mode            (crystal_mode),
  .rc_mode                 (rc_mode),
  .cap_mode                (cap_mode),
  .cmos_mode               (cmos_mode),
  .sfr_wdata               (sfr_wdata),
  .sfr_rdata               (sfr_rdata),
  .drive_frequency_control (drive_frequency_control),
  .k_factor_x100           (k_factor_x100)
);
`default_nettype wire

/* File: testbench/eoc_osc_model.sv */
// behavioural external crystal or clock source
`timescale 1ns/10ps
`default_nettype none
module eoc_osc_model (
  input  wire logic run,
  input  wire logic xtal,
  output logic xin,
  output logic xout,
  output logic stable
);
  int n;
  initial begin
    {xin, xout, stable, n} = 0;
    forever begin
      #40;
      xout = run ? !xout : xout;
      xin = run ? !xout : xin;
      n = (run && xtal) ? n + 1 : 0;
      stable = n > 25;
    end
  end
endmodule // eoc_osc_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk, rst_n, sfr_wr, sfr_rd, hv;
  logic [7:0]  sfr_addr, sfr_page, sfr_wdata, rv;
  wire  [7:0]  sfr_rdata;
  wire  [17:0] k_factor_x100;
  wire  [2:0]  drive_frequency_control;
  wire         sfr_hit, crystal_stable, oscillator_input_pin, oscillator_output_pin, osc_enable, ext_clk_out;
  wire         input_pin_claimed, output_pin_claimed, crystal_mode, rc_mode, cap_mode, cmos_mode;
  int          n_mismatch, n_checks;
  eoc_ext_osc_ctrl uut (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .sfr_addr                (sfr_addr),
    .sfr_page                (sfr_page),
    .sfr_wr                  (sfr_wr),
    .sfr_rd                  (sfr_rd),
    .sfr_wdata               (sfr_wdata),
    .sfr_rdata               (sfr_rdata),
    .sfr_hit                 (sfr_hit),
    .crystal_stable          (crystal_stable),
    .oscillator_input_pin    (oscillator_input_pin),
    .oscillator_output_pin   (oscillator_output_pin),
    .osc_enable              (osc_enable),
    .input_pin_claimed       (input_pin_claimed),
    .output_pin_claimed      (output_pin_claimed),
    .crystal_mode            (crystal_mode),
    .rc_mode                 (rc_mode),
    .cap_mode                (cap_mode),
    .cmos_mode               (cmos_mode),
    .drive_frequency_control (drive_frequency_control),
    .k_factor_x100           (k_factor_x100),
    .ext_clk_out             (ext_clk_out)
  );
  eoc_osc_model osc (.run(output_pin_claimed), .xtal(crystal_mode), .xin(oscillator_input_pin),
    .xout(oscillator_output_pin), .stable(crystal_stable));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(string nm, logic [17:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one register access, read data kept in rv
  task automatic acc(logic w, logic [7:0] a, d);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
    #1 hv = sfr_hit;
    @(posedge clk) #1;
    rv = sfr_rdata;
    {sfr_wr, sfr_rd} = 0;
    @(posedge clk) #1;
  endtask
  task automatic t_reset;
    acc(0, 8'h9f, 8'h00);
    chk("reset value", rv, 8'h00);
    chk("hit", hv, 1);
    acc(1, 8'h9e, 8'h60);
    chk("other address", osc_enable, 0);
    chk("hit other address", hv, 0);
    sfr_page = 8'h0e;
    acc(1, 8'h9f, 8'h60);
    chk("other page", osc_enable, 0);
    chk("hit other page", hv, 0);
    sfr_page = 8'h0f;
  endtask
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      acc(1, 8'h9f, {1'b1, m[2:0], 4'hd});
      chk("enable", {output_pin_claimed, osc_enable}, {2{m > 1}});
      chk("cmos", cmos_mode, m[2:1] == 1);
      chk("rc cap", {rc_mode, cap_mode}, {m == 4, m == 5});
      chk("crystal", {input_pin_claimed, crystal_mode}, {2{m > 5}});
      chk("drive", drive_frequency_control, (m == 4 || m > 5) ? 17'h5 : 17'h0);
      acc(0, 8'h9f, 8'h00);
      chk("read back", rv, {1'b0, m[2:0], 4'h5});
    end
  endtask
  task automatic t_kfactor;
    int kf[8] = '{87, 260, 770, 2200, 6500, 18000, 66400, 159000};
    for (int d = 0; d < 8; d++) begin
      acc(1, 8'h9f, {5'h0a, d[2:0]});
      chk("k factor", k_factor_x100, kf[d]);
    end
  endtask
  task automatic t_crystal;
    // enable, wait, poll; clock switch left to system logic
    acc(1, 8'h9f, 8'h67);
    acc(0, 8'h9f, 8'h00);
    chk("valid early", rv, 8'h67);
    // settling wait, scaled to the model
    repeat (64) @(posedge clk);
    #1;
    // flag polled only in crystal mode
    for (int i = 0; i < 100 && !rv[7]; i++) acc(0, 8'h9f, 8'h00);
    chk("valid set", rv, 8'he7);
    // drive lowered to 000 once stable
    acc(1, 8'h9f, 8'h60);
    acc(0, 8'h9f, 8'h00);
    chk("low drive keeps valid", rv, 8'he0);
    chk("low drive applied", drive_frequency_control, 0);
    acc(1, 8'h9f, 8'h47);
    acc(0, 8'h9f, 8'h00);
    chk("valid off", rv, 8'h47);
  endtask
  task automatic t_clock;
    logic [3:0] md[4] = '{1, 2, 3, 7};
    int ex[4] = '{0, 40, 20, 20};
    int n;
    logic p;
    for (int m = 0; m < 4; m++) begin
      acc(1, 8'h9f, {md[m], 4'h7});
      n = 0;
      p = ext_clk_out;
      repeat (400) begin
        @(posedge clk) #1;
        n += ext_clk_out && !p;
        p = ext_clk_out;
      end
      chk("clock rises", n >= ex[m] - 1 && n <= ex[m] + 1, 1);
    end
  endtask
  initial begin
    #400000;
    n_mismatch++;
    results;
  end
  initial begin
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, rst_n, n_mismatch, n_checks} = 0;
    sfr_page = 8'h0f;
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    #1;
    t_reset;
    t_modes;
    t_kfactor;
    t_crystal;
    t_clock;
    results;
  end
endmodule // tb_top
`default_nettype wire
